// ### rtl/ecs_pkg.sv
// Purpose: constants for external bus chip-select assignment and nand lane routing
// Assumes: single system clock, synchronous active-high reset
// Notes: reset values and fixed defaults listed below
package ecs_pkg;
  localparam int ADDR_W = 26;
  localparam int ALE_BIT = 21;
  localparam int CLE_BIT = 22;
  localparam int LANE_W = 16;
  localparam logic RST_CS1_ASSIGN = 1'h0;
  localparam logic RST_CS3_ASSIGN = 1'h0;
  localparam logic RST_UPPER_LANE = 1'h0;
  // static controller mode defaults
  localparam logic RST_BYTE_SELECT = 1'h1;
  localparam logic RST_BUS_16 = 1'h1;
  localparam logic RST_CS_STROBES = 1'h1;
  // pin levels during reset and while idle
  localparam logic RST_CS1_N = 1'h1;
  localparam logic RST_STROBE_N = 1'h1;
  localparam logic RST_LATCH = 1'h0;
endpackage : ecs_pkg

// ### rtl/ecs_lane_mux.sv
// Purpose: nand data lane steering between lower and upper halves
// Assumes: lane select registered by parent
// Notes: data output registered
`timescale 1ns/100ps
module ecs_lane_mux (
  input wire logic mclk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic upper_i, // nand on upper lanes
  input wire logic [15:0] nand_wdata_i, // nand write data
  input wire logic [31:0] bus_rdata_i, // data pins in
  output logic [31:0] lane_wdata_o, // data onto pins
  output logic [15:0] nand_rdata_o // nand read data
);
  logic [31:0] next_lane_wdata;
  logic [15:0] next_nand_rdata;
  always_comb begin
    next_lane_wdata = {16'h0000, nand_wdata_i};
    next_nand_rdata = bus_rdata_i[15:0];
    if (upper_i) begin
      next_lane_wdata = {nand_wdata_i, 16'h0000};
      next_nand_rdata = bus_rdata_i[31:16];
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lane_wdata_o <= 32'h00000000;
      nand_rdata_o <= 16'h0000;
    end else begin
      lane_wdata_o <= next_lane_wdata;
      nand_rdata_o <= next_nand_rdata;
    end
  end
  property p_lane_up;
    @(posedge mclk_i) disable iff (rst_i)
      upper_i |=> lane_wdata_o[31:16] == $past(nand_wdata_i) && lane_wdata_o[15:0] == 16'h0000;
  endproperty
  a_lane_up: assert property (p_lane_up) else $error("upper write lanes wrong");
  property p_lane_up_rd;
    @(posedge mclk_i) disable iff (rst_i)
      upper_i |=> nand_rdata_o == $past(bus_rdata_i[31:16]);
  endproperty
  a_lane_up_rd: assert property (p_lane_up_rd) else $error("upper read lanes wrong");
  property p_lane_low;
    @(posedge mclk_i) disable iff (rst_i)
      !upper_i |=> nand_rdata_o == $past(bus_rdata_i[15:0]);
  endproperty
  a_lane_low: assert property (p_lane_low) else $error("lower read lanes wrong");
  property p_lane_low_wr;
    @(posedge mclk_i) disable iff (rst_i)
      !upper_i |=> lane_wdata_o == {16'h0000, $past(nand_wdata_i)};
  endproperty
  a_lane_low_wr: assert property (p_lane_low_wr) else $error("lower write lanes wrong");
endmodule : ecs_lane_mux

// ### rtl/ecs_top.sv
// Purpose: chip-select assignment, nand strobe gating and lane routing
// Assumes: config bits come from logic on the same clock
// Notes: strobe inputs active low as driven by the static controller
`timescale 1ns/100ps
module ecs_top (
  input wire logic mclk_i, // system clock 200 MHz
  input wire logic rst_i, // sync reset
  input wire logic cfg_we_i, // load configuration bits
  input wire logic ram_cs1_assign_bit_i, // cs1 to dram
  input wire logic nand_cs3_assign_bit_i, // cs3 to nand
  input wire logic nand_upper_lane_select_i, // nand on d16-d31
  input wire logic [25:0] addr_i, // static controller address
  input wire logic smc_cs1_n_i, // static cs1 request
  input wire logic dram_cs1_n_i, // dram cs1 request
  input wire logic chip_select_three_n_i, // static cs3
  input wire logic smc_rd_n_i, // static read strobe
  input wire logic smc_wr_n_i, // static write strobe
  input wire logic [15:0] nand_wdata_i, // nand write data
  input wire logic [31:0] bus_rdata_i, // data pins in
  output logic ram_cs1_assign_bit_o, // cs1 assign readback
  output logic nand_cs3_assign_bit_o, // cs3 assign readback
  output logic nand_upper_lane_select_o, // lane readback
  output logic smc_byte_select_o, // static byte select mode
  output logic smc_bus_16_o, // static 16-bit bus
  output logic smc_cs_strobes_o, // strobes ruled by cs
  output logic cs1_n_o, // chip select 1 pin
  output logic nand_read_strobe_n_o, // nand read pin
  output logic nand_write_strobe_n_o, // nand write pin
  output logic nand_ale_o, // address latch
  output logic nand_cle_o, // command latch
  output logic [31:0] lane_wdata_o, // data pins out
  output logic [15:0] nand_rdata_o // nand read data
);
  // ==========================================================
  // configuration
  logic cs1a, cs3a, upper;
  logic next_cs1a, next_cs3a, next_upper;
  always_comb begin
    next_cs1a = cs1a;
    next_cs3a = cs3a;
    next_upper = upper;
    if (cfg_we_i) begin
      next_cs1a = ram_cs1_assign_bit_i;
      next_cs3a = nand_cs3_assign_bit_i;
      next_upper = nand_upper_lane_select_i;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cs1a <= ecs_pkg::RST_CS1_ASSIGN;
      cs3a <= ecs_pkg::RST_CS3_ASSIGN;
      upper <= ecs_pkg::RST_UPPER_LANE;
    end else begin
      cs1a <= next_cs1a;
      cs3a <= next_cs3a;
      upper <= next_upper;
    end
  end
  assign ram_cs1_assign_bit_o = cs1a;
  assign nand_cs3_assign_bit_o = cs3a;
  assign nand_upper_lane_select_o = upper;

  // ==========================================================
  // static controller defaults
  // held at reset values so a 16-bit part on chip select zero can boot
  assign smc_byte_select_o = ecs_pkg::RST_BYTE_SELECT;
  assign smc_bus_16_o = ecs_pkg::RST_BUS_16;
  assign smc_cs_strobes_o = ecs_pkg::RST_CS_STROBES;

  // ==========================================================
  // pin outputs
  // strobes park high outside the nand window: no stray static access reaches the flash
  function automatic logic latch_bit(input logic act, input logic [25:0] addr, input int pos);
    return act && addr[pos];
  endfunction : latch_bit
  logic cs3_act;
  logic next_cs1_n, next_rd_n, next_wr_n, next_ale, next_cle;
  always_comb begin
    cs3_act = cs3a && !chip_select_three_n_i;
    next_cs1_n = cs1a ? dram_cs1_n_i : smc_cs1_n_i;
    next_rd_n = cs3_act ? smc_rd_n_i : 1'h1;
    next_wr_n = cs3_act ? smc_wr_n_i : 1'h1;
    next_ale = latch_bit(cs3_act, addr_i, ecs_pkg::ALE_BIT);
    next_cle = latch_bit(cs3_act, addr_i, ecs_pkg::CLE_BIT);
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cs1_n_o <= ecs_pkg::RST_CS1_N;
      nand_read_strobe_n_o <= ecs_pkg::RST_STROBE_N;
      nand_write_strobe_n_o <= ecs_pkg::RST_STROBE_N;
      nand_ale_o <= ecs_pkg::RST_LATCH;
      nand_cle_o <= ecs_pkg::RST_LATCH;
    end else begin
      cs1_n_o <= next_cs1_n;
      nand_read_strobe_n_o <= next_rd_n;
      nand_write_strobe_n_o <= next_wr_n;
      nand_ale_o <= next_ale;
      nand_cle_o <= next_cle;
    end
  end

  // ==========================================================
  // data lanes
  ecs_lane_mux u_lane (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .upper_i(upper),
    .nand_wdata_i(nand_wdata_i),
    .bus_rdata_i(bus_rdata_i),
    .lane_wdata_o(lane_wdata_o),
    .nand_rdata_o(nand_rdata_o)
  );

  // ==========================================================
  // checks
  property p_cs1_dram;
    @(posedge mclk_i) disable iff (rst_i)
      cs1a |=> cs1_n_o == $past(dram_cs1_n_i);
  endproperty
  a_cs1_dram: assert property (p_cs1_dram) else $error("cs1 not from dram");

  property p_dram_isolate;
    @(posedge mclk_i) disable iff (rst_i)
      cs1a && !smc_cs1_n_i && dram_cs1_n_i |=> cs1_n_o;
  endproperty
  a_dram_isolate: assert property (p_dram_isolate) else $error("static reached cs1");

  property p_cs1a_load;
    @(posedge mclk_i) disable iff (rst_i)
      cfg_we_i |=> ram_cs1_assign_bit_o == $past(ram_cs1_assign_bit_i);
  endproperty
  a_cs1a_load: assert property (p_cs1a_load) else $error("cs1 bit not loaded");

  property p_cs1_smc;
    @(posedge mclk_i) disable iff (rst_i)
      !cs1a |=> cs1_n_o == $past(smc_cs1_n_i);
  endproperty
  a_cs1_smc: assert property (p_cs1_smc) else $error("cs1 not from static");

  property p_smc_isolate;
    @(posedge mclk_i) disable iff (rst_i)
      !cs1a && !dram_cs1_n_i && smc_cs1_n_i |=> cs1_n_o;
  endproperty
  a_smc_isolate: assert property (p_smc_isolate) else $error("dram reached cs1");

  property p_cfg_hold;
    @(posedge mclk_i) disable iff (rst_i)
      !cfg_we_i |=> $stable(cs1a) && $stable(cs3a) && $stable(upper);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");

  property p_cs3a_load;
    @(posedge mclk_i) disable iff (rst_i)
      cfg_we_i |=> nand_cs3_assign_bit_o == $past(nand_cs3_assign_bit_i);
  endproperty
  a_cs3a_load: assert property (p_cs3a_load) else $error("cs3 bit not loaded");

  property p_no_nand;
    @(posedge mclk_i) disable iff (rst_i)
      !cs3a |=> nand_read_strobe_n_o && nand_write_strobe_n_o && !nand_ale_o && !nand_cle_o;
  endproperty
  a_no_nand: assert property (p_no_nand) else $error("nand active while off");

  property p_lane_load;
    @(posedge mclk_i) disable iff (rst_i)
      cfg_we_i |=> nand_upper_lane_select_o == $past(nand_upper_lane_select_i);
  endproperty
  a_lane_load: assert property (p_lane_load) else $error("lane bit not loaded");

  property p_ale;
    @(posedge mclk_i) disable iff (rst_i)
      cs3_act |=> nand_ale_o == $past(addr_i[ecs_pkg::ALE_BIT]);
  endproperty
  a_ale: assert property (p_ale) else $error("address latch wrong");

  property p_cle;
    @(posedge mclk_i) disable iff (rst_i)
      cs3_act |=> nand_cle_o == $past(addr_i[ecs_pkg::CLE_BIT]);
  endproperty
  a_cle: assert property (p_cle) else $error("command latch wrong");

  property p_latch_idle;
    @(posedge mclk_i) disable iff (rst_i)
      !cs3_act |=> !nand_ale_o && !nand_cle_o;
  endproperty
  a_latch_idle: assert property (p_latch_idle) else $error("latch outside cs3");

  property p_rd_pass;
    @(posedge mclk_i) disable iff (rst_i)
      cs3_act |=> nand_read_strobe_n_o == $past(smc_rd_n_i);
  endproperty
  a_rd_pass: assert property (p_rd_pass) else $error("read strobe not passed");

  property p_wr_pass;
    @(posedge mclk_i) disable iff (rst_i)
      cs3_act |=> nand_write_strobe_n_o == $past(smc_wr_n_i);
  endproperty
  a_wr_pass: assert property (p_wr_pass) else $error("write strobe not passed");

  property p_leave;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(chip_select_three_n_i) |=> nand_read_strobe_n_o && nand_write_strobe_n_o;
  endproperty
  a_leave: assert property (p_leave) else $error("strobe after cs3 left");

  property p_strobe_idle;
    @(posedge mclk_i) disable iff (rst_i)
      !cs3_act |=> nand_read_strobe_n_o && nand_write_strobe_n_o;
  endproperty
  a_strobe_idle: assert property (p_strobe_idle) else $error("strobe outside cs3");

  property p_rst_pins;
    @(posedge mclk_i)
      rst_i |=> cs1_n_o && nand_read_strobe_n_o && nand_write_strobe_n_o
        && !nand_ale_o && !nand_cle_o;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins not idle in reset");

  property p_rst_lane;
    @(posedge mclk_i) rst_i |=> !upper && !nand_upper_lane_select_o;
  endproperty
  a_rst_lane: assert property (p_rst_lane) else $error("lane not zero in reset");

  property p_defaults;
    @(posedge mclk_i) disable iff (rst_i)
      smc_byte_select_o && smc_bus_16_o && smc_cs_strobes_o;
  endproperty
  a_defaults: assert property (p_defaults) else $error("static defaults lost");
endmodule : ecs_top

// ### dv/ecs_mem_model.sv
// Purpose: external nand data model on the shared data pins
// Assumes: read pin active low, lane wiring follows the lane select
// Notes: released lines toggle so a stale value never looks valid
`timescale 1ns/100ps
module ecs_mem_model (
  input wire logic mclk_i, // system clock
  input wire logic upper_i, // nand wired to upper lanes
  input wire logic rd_n_i, // nand read pin
  output logic [31:0] bus_o // data onto pins
);
  // ready/busy goes to a general io line, so nothing here answers the block
  // one 16-bit half only; the dram width and pin functions stay with software
  // 8 and 16 bit parts differ only in the static width, so one model serves both
  localparam logic [15:0] PAT = 16'h96e1;
  logic [31:0] bus = 32'h0;
  always_ff @(posedge mclk_i) begin
    if (!rd_n_i) begin
      bus <= upper_i ? {PAT, ~PAT} : {~PAT, PAT};
    end else begin
      bus <= ~bus;
    end
  end
  assign bus_o = bus;
endmodule : ecs_mem_model

// ### dv/tb_top.sv
// Purpose: bench for chip-select assignment, nand strobes and lanes
// Assumes: inputs driven at the falling edge
// Notes: outputs are registered, checked one to three cycles later
`timescale 1ns/100ps
module tb_top;
  logic mclk_i = 1'h0;
  logic rst_i = 1'h1;
  logic we = 1'h0, c1 = 1'h0, c3 = 1'h0, up = 1'h0;
  logic [25:0] addr = 26'h0;
  logic s1_n = 1'h1, d1_n = 1'h1, c3_n = 1'h1, rd_n = 1'h1, wr_n = 1'h1;
  logic [15:0] wd = 16'hc35a;
  logic [31:0] rdb, lw;
  logic [15:0] nrd;
  logic c1o, c3o, upo, bso, b16, cso, cs1o, nro, nwo, ale, cle;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  always #2.5 mclk_i = ~mclk_i;
  ecs_top i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .cfg_we_i(we), .ram_cs1_assign_bit_i(c1),
    .nand_cs3_assign_bit_i(c3), .nand_upper_lane_select_i(up), .addr_i(addr),
    .smc_cs1_n_i(s1_n), .dram_cs1_n_i(d1_n), .chip_select_three_n_i(c3_n),
    .smc_rd_n_i(rd_n), .smc_wr_n_i(wr_n), .nand_wdata_i(wd), .bus_rdata_i(rdb),
    .ram_cs1_assign_bit_o(c1o), .nand_cs3_assign_bit_o(c3o), .nand_upper_lane_select_o(upo),
    .smc_byte_select_o(bso), .smc_bus_16_o(b16), .smc_cs_strobes_o(cso), .cs1_n_o(cs1o),
    .nand_read_strobe_n_o(nro), .nand_write_strobe_n_o(nwo), .nand_ale_o(ale),
    .nand_cle_o(cle), .lane_wdata_o(lw), .nand_rdata_o(nrd));
  ecs_mem_model i_mem (.mclk_i(mclk_i), .upper_i(up), .rd_n_i(nro), .bus_o(rdb));
  task automatic step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : step
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cfg(input logic a, input logic b, input logic u);
    c1 = a;
    c3 = b;
    up = u;
    we = 1'h1;
    step(1);
    we = 1'h0;
    step(1);
  endtask : cfg
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic test_reset();
    chk("lane readback", upo, 1'h0);
    chk("byte select", bso, 1'h1);
    chk("bus 16", b16, 1'h1);
    chk("cs strobes", cso, 1'h1);
    $display("test reset done");
  endtask : test_reset
  task automatic test_cs1();
    cfg(1'h0, 1'h0, 1'h0);
    s1_n = 1'h0;
    step(1);
    chk("cs1 static", cs1o, 1'h0);
    s1_n = 1'h1;
    d1_n = 1'h0;
    step(1);
    chk("cs1 ignores dram", cs1o, 1'h1);
    cfg(1'h1, 1'h0, 1'h0);
    chk("cs1 readback", c1o, 1'h1);
    chk("cs1 dram", cs1o, 1'h0);
    d1_n = 1'h1;
    s1_n = 1'h0;
    step(1);
    chk("cs1 ignores static", cs1o, 1'h1);
    s1_n = 1'h1;
    $display("test cs1 done");
  endtask : test_cs1
  task automatic test_nand();
    cfg(1'h0, 1'h1, 1'h0);
    chk("cs3 readback", c3o, 1'h1);
    c3_n = 1'h0;
    addr = 26'h0200000;
    rd_n = 1'h0;
    step(1);
    chk("ale", {ale, cle}, 2'h2);
    chk("read strobe", nro, 1'h0);
    addr = 26'h0400000;
    rd_n = 1'h1;
    wr_n = 1'h0;
    step(1);
    chk("cle", {ale, cle, nro, nwo}, 4'h6);
    c3_n = 1'h1;
    step(1);
    chk("idle cs3", {cle, nwo}, 2'h1);
    c3_n = 1'h0;
    cfg(1'h0, 1'h0, 1'h0);
    chk("nand off", {cle, nwo}, 2'h1);
    chk("cs3 cleared", c3o, 1'h0);
    c3_n = 1'h1;
    wr_n = 1'h1;
    addr = 26'h0;
    $display("test nand done");
  endtask : test_nand
  task automatic test_lanes();
    for (int u = 0; u < 2; u++) begin
      cfg(1'h0, 1'h1, u[0]);
      c3_n = 1'h0;
      rd_n = 1'h0;
      // read pin falls, then the model answers, then the lane flop takes it
      step(3);
      chk("lane wdata", lw, u[0] ? {wd, 16'h0} : {16'h0, wd});
      chk("nand rdata", nrd, 16'h96e1);
      c3_n = 1'h1;
      rd_n = 1'h1;
    end
    $display("test lanes done");
  endtask : test_lanes
  task automatic test_rerst();
    cfg(1'h1, 1'h1, 1'h1);
    chk("lane set", upo, 1'h1);
    rst_i = 1'h1;
    step(2);
    rst_i = 1'h0;
    chk("lane after reset", upo, 1'h0);
    chk("cs3 after reset", c3o, 1'h0);
    chk("cs1 after reset", {c1o, cs1o}, 2'h1);
    chk("nand rdata after reset", nrd, 16'h0);
    step(1);
    $display("test reset again done");
  endtask : test_rerst
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    step(2);
    rst_i = 1'h0;
    test_reset();
    test_cs1();
    test_nand();
    test_lanes();
    test_rerst();
    end_of_test();
  end
endmodule : tb_top
